/* common/mqaf_map.vh */
// mqaf_map.vh: constants for the multi-queue almost-flag logic.
// assumes plain verilog-2005 and inclusion by bare name.
`ifndef MQAF_MAP_VH
`define MQAF_MAP_VH

// queue set and per-queue geometry
`define MQAF_NQ 128
`define MQAF_QW 7
`define MQAF_LW 10
`define MQAF_DEPTH 10'h200

// offsets chosen by default programming
`define MQAF_OFF_LO 10'h008
`define MQAF_OFF_HI 10'h080

// reset values of counters and status
`define MQAF_LEVEL_RST 10'h000
`define MQAF_QUEUE_RST 7'h00
`define MQAF_FLAG_OFF 1'h1

`endif

/* rtl/mqaf_flags.v */
// mqaf_flags.v: active-queue almost-full and almost-empty flags of a multi-queue buffer.
// assumes one clock for both ports; write and read strobes are synchronous to it.
// Function
// - track almost-full for every queue; output only the write-selected one.
// - per-queue almost-full offset, 0 to depth; default offset 8 or 128.
// - new write queue's almost-full shows on third edge after selection.
// - write reaching the boundary drives almost-full low three cycles later.
// - read leaving almost-full raises flag after skew window plus one cycle.
// - missed skew window adds one cycle to read-caused almost-full update.
// - almost-full changes only on clock rising edges.
// - almost-full status of unselected queues follows reads on them.
// - track almost-empty for every queue; output only the read-selected one.
// - per-queue almost-empty offset, 0 to depth; default 8 or 128.
// - new read queue's almost-empty shows on third edge after selection.
// - read reaching the boundary drives almost-empty low three cycles later.
// - write leaving almost-empty raises flag after skew window plus one cycle.
// - missed skew window adds one cycle to write-caused almost-empty update.
// - almost-empty changes only on clock rising edges.
// - almost-empty status of unselected queues follows writes on them.
`include "mqaf_map.vh"
`timescale 1ns/10ps
`default_nettype none

module mqaf_flags (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_i,
  // default programming choice, sampled while reset is high
  input wire default_offset_hi_i,
  // per-queue offset programming
  input wire prog_en_i,
  input wire [`MQAF_QW-1:0] prog_queue_i,
  input wire [`MQAF_LW-1:0] prog_af_offset_i,
  input wire [`MQAF_LW-1:0] prog_ae_offset_i,
  // write port
  input wire [`MQAF_QW-1:0] wr_queue_addr_i,
  input wire wr_addr_enable_i,
  input wire wr_en_i,
  input wire wr_skew_miss_i,
  // read port
  input wire [`MQAF_QW-1:0] rd_queue_addr_i,
  input wire rd_addr_enable_i,
  input wire rd_en_i,
  input wire rd_skew_miss_i,
  // active-queue flags
  output reg almost_full_n_o,
  output reg almost_empty_n_o
);

  // offsets are clamped to the queue depth
  function [`MQAF_LW-1:0] mqaf_clamp;
    input [`MQAF_LW-1:0] off;
    begin
      mqaf_clamp = (off > `MQAF_DEPTH) ? `MQAF_DEPTH : off;
    end
  endfunction

  // almost-full test on free space, active low
  function mqaf_af_n;
    input [`MQAF_LW-1:0] level;
    input [`MQAF_LW-1:0] off;
    begin
      mqaf_af_n = ~((`MQAF_DEPTH - level) <= off);
    end
  endfunction

  // almost-empty test on fill level, active low
  function mqaf_ae_n;
    input [`MQAF_LW-1:0] level;
    input [`MQAF_LW-1:0] off;
    begin
      mqaf_ae_n = ~(level <= off);
    end
  endfunction

  // one-hot decode of an event against a queue number
  function mqaf_hit;
    input evt;
    input [`MQAF_QW-1:0] q;
    input [`MQAF_QW-1:0] idx;
    begin
      mqaf_hit = evt && (q == idx);
    end
  endfunction

  // count of two coincident events, 0 to 2
  function [1:0] mqaf_pair;
    input a;
    input b;
    begin
      mqaf_pair = {1'b0, a} + {1'b0, b};
    end
  endfunction

  // level step with saturation at both ends; up to two events either way
  function [`MQAF_LW-1:0] mqaf_step;
    input [`MQAF_LW-1:0] level;
    input [1:0] up;
    input [1:0] down;
    reg [`MQAF_LW+1:0] t;
    begin
      t = {2'b00, level} + {{`MQAF_LW{1'b0}}, up};
      if (t < {{`MQAF_LW{1'b0}}, down}) begin
        mqaf_step = `MQAF_LEVEL_RST;
      end else begin
        t = t - {{`MQAF_LW{1'b0}}, down};
        mqaf_step = (t > {2'b00, `MQAF_DEPTH}) ? `MQAF_DEPTH : t[`MQAF_LW-1:0];
      end
    end
  endfunction

  // per-queue memories
  reg [`MQAF_LW-1:0] af_off_r [0:`MQAF_NQ-1];
  reg [`MQAF_LW-1:0] ae_off_r [0:`MQAF_NQ-1];
  reg [`MQAF_LW-1:0] wr_level_r [0:`MQAF_NQ-1];
  reg [`MQAF_LW-1:0] rd_level_r [0:`MQAF_NQ-1];
  reg [`MQAF_NQ-1:0] af_stat_r;
  reg [`MQAF_NQ-1:0] ae_stat_r;

  // per-queue event hits of this cycle
  reg [`MQAF_NQ-1:0] wr_own_hit;
  reg [`MQAF_NQ-1:0] rd_own_hit;
  reg [`MQAF_NQ-1:0] rd_fast_hit;
  reg [`MQAF_NQ-1:0] rd_slow_hit;
  reg [`MQAF_NQ-1:0] wr_fast_hit;
  reg [`MQAF_NQ-1:0] wr_slow_hit;

  // queue selection pipelines
  reg [`MQAF_QW-1:0] wq_sel_r;
  reg [`MQAF_QW-1:0] wq_d1_r;
  reg [`MQAF_QW-1:0] wq_act_r;
  reg [`MQAF_QW-1:0] rq_sel_r;
  reg [`MQAF_QW-1:0] rq_d1_r;
  reg [`MQAF_QW-1:0] rq_act_r;

  // first buffer stage of each output flag
  reg af_buf_r;
  reg ae_buf_r;

  // cross-side event lanes
  wire rd_fast_evt;
  wire [`MQAF_QW-1:0] rd_fast_q;
  wire rd_slow_evt;
  wire [`MQAF_QW-1:0] rd_slow_q;
  wire wr_fast_evt;
  wire [`MQAF_QW-1:0] wr_fast_q;
  wire wr_slow_evt;
  wire [`MQAF_QW-1:0] wr_slow_q;

  // loop indices, one per process so no two processes share a variable
  integer i_off;
  integer i_dec;
  integer i_wl;
  integer i_rl;
  integer i_af;
  integer i_ae;

  // reads reach the almost-full side one cycle late, or two on a skew miss
  mqaf_xdelay u_rd_to_af (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .evt_i(rd_en_i),
    .queue_i(rq_act_r),
    .skew_miss_i(rd_skew_miss_i),
    .fast_evt_o(rd_fast_evt),
    .fast_queue_o(rd_fast_q),
    .slow_evt_o(rd_slow_evt),
    .slow_queue_o(rd_slow_q)
  );

  // writes reach the almost-empty side the same way
  mqaf_xdelay u_wr_to_ae (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .evt_i(wr_en_i),
    .queue_i(wq_act_r),
    .skew_miss_i(wr_skew_miss_i),
    .fast_evt_o(wr_fast_evt),
    .fast_queue_o(wr_fast_q),
    .slow_evt_o(wr_slow_evt),
    .slow_queue_o(wr_slow_q)
  );

  // offset store; reset loads the default for every queue
  always @(posedge ref_clk_i) begin
    for (i_off = 0; i_off < `MQAF_NQ; i_off = i_off + 1) begin
      if (reset_i) begin
        af_off_r[i_off] <= default_offset_hi_i ? `MQAF_OFF_HI : `MQAF_OFF_LO;
        ae_off_r[i_off] <= default_offset_hi_i ? `MQAF_OFF_HI : `MQAF_OFF_LO;
      end else if (prog_en_i && (prog_queue_i == i_off[`MQAF_QW-1:0])) begin
        af_off_r[i_off] <= mqaf_clamp(prog_af_offset_i);
        ae_off_r[i_off] <= mqaf_clamp(prog_ae_offset_i);
      end
    end
  end

  // write queue select: captured edge, one delay, then active from the third edge
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      wq_sel_r <= `MQAF_QUEUE_RST;
      wq_d1_r <= `MQAF_QUEUE_RST;
      wq_act_r <= `MQAF_QUEUE_RST;
    end else begin
      if (wr_addr_enable_i) begin
        wq_sel_r <= wr_queue_addr_i;
      end
      wq_d1_r <= wq_sel_r;
      wq_act_r <= wq_d1_r; // no write reaches a queue before its flag shows
    end
  end

  // read queue select mirrors the write side
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      rq_sel_r <= `MQAF_QUEUE_RST;
      rq_d1_r <= `MQAF_QUEUE_RST;
      rq_act_r <= `MQAF_QUEUE_RST;
    end else begin
      if (rd_addr_enable_i) begin
        rq_sel_r <= rd_queue_addr_i;
      end
      rq_d1_r <= rq_sel_r;
      rq_act_r <= rq_d1_r;
    end
  end

  // one-hot event decode; each event hits at most one queue
  always @* begin
    wr_own_hit = {`MQAF_NQ{1'b0}};
    rd_own_hit = {`MQAF_NQ{1'b0}};
    rd_fast_hit = {`MQAF_NQ{1'b0}};
    rd_slow_hit = {`MQAF_NQ{1'b0}};
    wr_fast_hit = {`MQAF_NQ{1'b0}};
    wr_slow_hit = {`MQAF_NQ{1'b0}};
    for (i_dec = 0; i_dec < `MQAF_NQ; i_dec = i_dec + 1) begin
      wr_own_hit[i_dec] = mqaf_hit(wr_en_i, wq_act_r, i_dec[`MQAF_QW-1:0]);
      rd_own_hit[i_dec] = mqaf_hit(rd_en_i, rq_act_r, i_dec[`MQAF_QW-1:0]);
      rd_fast_hit[i_dec] = mqaf_hit(rd_fast_evt, rd_fast_q, i_dec[`MQAF_QW-1:0]);
      rd_slow_hit[i_dec] = mqaf_hit(rd_slow_evt, rd_slow_q, i_dec[`MQAF_QW-1:0]);
      wr_fast_hit[i_dec] = mqaf_hit(wr_fast_evt, wr_fast_q, i_dec[`MQAF_QW-1:0]);
      wr_slow_hit[i_dec] = mqaf_hit(wr_slow_evt, wr_slow_q, i_dec[`MQAF_QW-1:0]);
    end
  end

  // write-side levels: own writes at once, reads late; idle queues stay current
  always @(posedge ref_clk_i) begin
    for (i_wl = 0; i_wl < `MQAF_NQ; i_wl = i_wl + 1) begin
      if (reset_i) begin
        wr_level_r[i_wl] <= `MQAF_LEVEL_RST;
      end else begin
        wr_level_r[i_wl] <= mqaf_step(wr_level_r[i_wl], {1'b0, wr_own_hit[i_wl]},
          mqaf_pair(rd_fast_hit[i_wl], rd_slow_hit[i_wl]));
      end
    end
  end

  // read-side levels: own reads at once; an on-time and a late write may meet
  always @(posedge ref_clk_i) begin
    for (i_rl = 0; i_rl < `MQAF_NQ; i_rl = i_rl + 1) begin
      if (reset_i) begin
        rd_level_r[i_rl] <= `MQAF_LEVEL_RST;
      end else begin
        rd_level_r[i_rl] <= mqaf_step(rd_level_r[i_rl],
          mqaf_pair(wr_fast_hit[i_rl], wr_slow_hit[i_rl]),
          {1'b0, rd_own_hit[i_rl]});
      end
    end
  end

  // almost-full status of all queues, one register stage after the level
  always @(posedge ref_clk_i) begin
    for (i_af = 0; i_af < `MQAF_NQ; i_af = i_af + 1) begin
      if (reset_i) begin
        af_stat_r[i_af] <= `MQAF_FLAG_OFF;
      end else begin
        af_stat_r[i_af] <= mqaf_af_n(wr_level_r[i_af], af_off_r[i_af]);
      end
    end
  end

  // almost-empty status of all queues, one register stage after the level
  always @(posedge ref_clk_i) begin
    for (i_ae = 0; i_ae < `MQAF_NQ; i_ae = i_ae + 1) begin
      if (reset_i) begin
        ae_stat_r[i_ae] <= ~`MQAF_FLAG_OFF;
      end else begin
        ae_stat_r[i_ae] <= mqaf_ae_n(rd_level_r[i_ae], ae_off_r[i_ae]);
      end
    end
  end

  // almost-full pin: double buffered so it only moves on a clock edge
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      af_buf_r <= `MQAF_FLAG_OFF;
      almost_full_n_o <= `MQAF_FLAG_OFF;
    end else begin
      af_buf_r <= af_stat_r[wq_d1_r];
      almost_full_n_o <= af_buf_r;
    end
  end

  // almost-empty pin: same two stages on the read side
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      ae_buf_r <= ~`MQAF_FLAG_OFF;
      almost_empty_n_o <= ~`MQAF_FLAG_OFF;
    end else begin
      ae_buf_r <= ae_stat_r[rq_d1_r];
      almost_empty_n_o <= ae_buf_r;
    end
  end

endmodule // mqaf_flags

`default_nettype wire

/* rtl/mqaf_xdelay.v */
// mqaf_xdelay.v: carries an event from one port to the other side's flag logic.
// assumes one common clock; skew_miss_i is given with the event it qualifies.
`timescale 1ns/10ps
`default_nettype none
`include "mqaf_map.vh"

module mqaf_xdelay (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_i,
  // event from the far port
  input wire evt_i,
  input wire [`MQAF_QW-1:0] queue_i,
  input wire skew_miss_i,
  // fast lane: one cycle after the event
  output wire fast_evt_o,
  output wire [`MQAF_QW-1:0] fast_queue_o,
  // slow lane: one cycle later when the skew window is missed
  output reg slow_evt_o,
  output reg [`MQAF_QW-1:0] slow_queue_o
);

  reg s1_evt_r;
  reg s1_miss_r;
  reg [`MQAF_QW-1:0] s1_queue_r;

  // two lanes so a late event never collides with the next on-time one
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      s1_evt_r <= 1'b0;
      s1_miss_r <= 1'b0;
      s1_queue_r <= `MQAF_QUEUE_RST;
      slow_evt_o <= 1'b0;
      slow_queue_o <= `MQAF_QUEUE_RST;
    end else begin
      s1_evt_r <= evt_i;
      s1_miss_r <= skew_miss_i;
      s1_queue_r <= queue_i;
      slow_evt_o <= s1_evt_r & s1_miss_r;
      slow_queue_o <= s1_queue_r;
    end
  end

  assign fast_evt_o = s1_evt_r & ~s1_miss_r;
  assign fast_queue_o = s1_queue_r;

endmodule // mqaf_xdelay

`default_nettype wire

/* testbench/mqaf_ctrl_model.sv */
// mqaf_ctrl_model.sv: system controller that selects queues and moves words.
// assumes the bench calls req() and that requests change at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module mqaf_ctrl_model (
  // clock
  input wire logic ref_clk_i,
  // strobes: wsel, rsel, write, read, skew miss, program
  output var logic [5:0] req_o,
  // queue for every request; almost-empty offset to program
  output var logic [6:0] queue_o,
  output var logic [9:0] ae_off_o
);
  // quiet bus from time zero
  initial begin
    req_o = 6'h00;
    queue_o = 7'h00;
    ae_off_o = 10'h1F6;
  end
  // strobes held for n edges; the queue stays put so a select is never smeared
  task req(input logic [5:0] op, input logic [6:0] q, input int n);
    @(negedge ref_clk_i);
    req_o = op;
    queue_o = q;
    repeat (n) @(negedge ref_clk_i);
    req_o = 6'h00;
  endtask
endmodule // mqaf_ctrl_model
`default_nettype wire

/* testbench/mqaf_flags_monitor.sv */
// mqaf_flags_monitor.sv: timing checks on the active-queue flags.
// assumes it is bound to mqaf_flags; one clock serves both ports.
`timescale 1ns/10ps
`default_nettype none
module mqaf_flags_monitor (
  // clock, reset and causes
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic wr_addr_enable_i,
  input wire logic rd_addr_enable_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic prog_en_i,
  // flags
  input wire logic almost_full_n_o,
  input wire logic almost_empty_n_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // flags idle for the pipeline depth after reset
  reset_af_a:
    assert property ($fell(reset_i) |-> almost_full_n_o [*3]) else $error("af not idle");
  reset_ae_a:
    assert property ($fell(reset_i) |-> !almost_empty_n_o [*3]) else $error("ae not idle");
  // each flag edge needs a cause an exact pipeline depth back
  af_fall_a:
    assert property ($fell(almost_full_n_o) |-> $past(wr_en_i, 4) || $past(wr_addr_enable_i, 4)
      || $past(prog_en_i, 4)) else $error("af fell without cause");
  af_rise_a:
    assert property ($rose(almost_full_n_o) |-> $past(rd_en_i, 5) || $past(rd_en_i, 6)
      || $past(wr_addr_enable_i, 4) || $past(prog_en_i, 4)) else $error("af rose without cause");
  ae_fall_a:
    assert property ($fell(almost_empty_n_o) |-> $past(rd_en_i, 4) || $past(rd_addr_enable_i, 4)
      || $past(prog_en_i, 4)) else $error("ae fell without cause");
  ae_rise_a:
    assert property ($rose(almost_empty_n_o) |-> $past(wr_en_i, 5) || $past(wr_en_i, 6)
      || $past(rd_addr_enable_i, 4) || $past(prog_en_i, 4)) else $error("ae rose without cause");
  // quiet ports leave both flags alone
  af_quiet_a:
    assert property ((!wr_en_i && !rd_en_i && !wr_addr_enable_i && !prog_en_i) [*6]
      |=> $stable(almost_full_n_o)) else $error("af moved on quiet ports");
  ae_quiet_a:
    assert property ((!wr_en_i && !rd_en_i && !rd_addr_enable_i && !prog_en_i) [*6]
      |=> $stable(almost_empty_n_o)) else $error("ae moved on quiet ports");
endmodule // mqaf_flags_monitor
`default_nettype wire

/* testbench/mqaf_flags_tb_top.sv */
// mqaf_flags_tb_top.sv: directed tests of the active-queue flags.
// assumes the controller model drives every request at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module mqaf_flags_tb_top;
  localparam logic [5:0] WS = 6'h20, RS = 6'h10, WR = 6'h08, RD = 6'h04, MS = 6'h02;
  logic ref_clk_i;
  logic reset_i;
  logic dflt_hi;
  wire logic [5:0] rq;
  wire logic [6:0] q;
  wire logic [9:0] aeo;
  wire logic af_n, ae_n;
  int miscompares;
  int check_count;
  // free-running clock
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  mqaf_ctrl_model mqaf_ctrl_model_i (.ref_clk_i(ref_clk_i), .req_o(rq), .queue_o(q),
    .ae_off_o(aeo));
  // one programming value serves both offsets; the default choice follows dflt_hi
  mqaf_flags mqaf_flags_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .default_offset_hi_i(dflt_hi), .prog_en_i(rq[0]), .prog_queue_i(q),
    .prog_af_offset_i(aeo), .prog_ae_offset_i(aeo), .wr_queue_addr_i(q),
    .wr_addr_enable_i(rq[5]), .wr_en_i(rq[3]), .wr_skew_miss_i(rq[1]),
    .rd_queue_addr_i(q), .rd_addr_enable_i(rq[4]), .rd_en_i(rq[2]),
    .rd_skew_miss_i(rq[1]), .almost_full_n_o(af_n), .almost_empty_n_o(ae_n));
  task r(input logic [5:0] op, input logic [6:0] qq, input int n);
    mqaf_ctrl_model_i.req(op, qq, n);
  endtask
  task cmp(input logic ae, input logic e);
    logic v;
    v = ae ? ae_n : af_n;
    check_count++;
    if (v !== e) begin
      $display("ERROR %s expected %b seen %b", ae ? "almost_empty_n_o" : "almost_full_n_o", e, v);
      miscompares++;
    end
  endtask
  // old value one edge before the expected change, new value on it
  task chk(input int k, input logic ae, input logic e);
    repeat (k - 2) @(negedge ref_clk_i);
    cmp(ae, !e);
    @(negedge ref_clk_i);
    cmp(ae, e);
  endtask
  task t_fill;
    r(WR, 7'h00, 504);
    chk(4, 0, 0);
  endtask
  task t_switch;
    r(WS, 7'h01, 1);
    chk(4, 0, 1);
    r(RD, 7'h00, 1);
    r(WS, 7'h00, 1);
    repeat (4) @(negedge ref_clk_i);
    cmp(0, 1);
  endtask
  task t_af_read;
    r(WR, 7'h00, 1);
    chk(4, 0, 0);
    r(RD, 7'h00, 1);
    chk(5, 0, 1);
    r(WR, 7'h00, 1);
    chk(4, 0, 0);
    r(RD | MS, 7'h00, 1);
    chk(6, 0, 1);
  endtask
  task t_ae;
    r(6'h01, 7'h00, 1);
    chk(4, 0, 0);
    r(RD, 7'h00, 1);
    chk(4, 1, 0);
    r(WR, 7'h00, 1);
    chk(5, 1, 1);
    r(RD, 7'h00, 1);
    chk(4, 1, 0);
    r(WR | MS, 7'h00, 1);
    chk(6, 1, 1);
  endtask
  task t_rsel;
    r(RS, 7'h01, 1);
    chk(4, 1, 0);
    r(RS, 7'h00, 1);
    chk(4, 1, 1);
    r(WS, 7'h01, 1);
    chk(4, 0, 1);
    r(WR, 7'h01, 9);
    r(RS, 7'h01, 1);
    repeat (4) @(negedge ref_clk_i);
    cmp(1, 1);
  endtask
  // second reset with the high default offsets on queue 0
  task t_hi;
    dflt_hi = 1'b1;
    reset_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    reset_i = 1'b0;
    cmp(0, 1);
    cmp(1, 0);
    r(WR, 7'h00, 129);
    chk(5, 1, 1);
    r(WR, 7'h00, 255);
    chk(4, 0, 0);
  endtask
  task stop_test;
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    miscompares = 0;
    check_count = 0;
    dflt_hi = 1'b0;
    reset_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    reset_i = 1'b0;
    cmp(0, 1);
    cmp(1, 0);
    t_fill;
    t_switch;
    t_af_read;
    t_ae;
    t_rsel;
    t_hi;
    stop_test;
  end
  // watchdog: the run needs about 1000 cycles
  initial begin
    #40000;
    miscompares++;
    stop_test;
  end
endmodule // mqaf_flags_tb_top
bind mqaf_flags mqaf_flags_monitor mqaf_flags_monitor_i (.ref_clk_i(ref_clk_i),
  .reset_i(reset_i), .wr_addr_enable_i(wr_addr_enable_i), .rd_addr_enable_i(rd_addr_enable_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .prog_en_i(prog_en_i),
  .almost_full_n_o(almost_full_n_o), .almost_empty_n_o(almost_empty_n_o));
`default_nettype wire
